// File: rtl/perc_node.sv
// Purpose: Permanent error decision, isolation and reconfiguration for one node.
// Assumes: Reports arrive as one-cycle strobes from same-clock logic; error line is a pin.
// Notes:   is_memory_node selects memory control behaviour over bus interface behaviour.
//          Isolation and activation are decided once, from the logged first report.
//          init_load wins over reconfiguration, so software can restore bus_state and married of a fenced node.
`timescale 1ns/1ps
module perc_node
    import perc_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    input  wire logic                 is_memory_node,
    input  wire logic [ID_W-1:0]      own_bus_id,
    input  wire logic [ID_W-1:0]      own_module_id,
    input  wire logic [ID_W-1:0]      partner_module_id,
    input  wire logic [ID_W-1:0]      backup_bus_id,
    input  wire logic [TMO_W-1:0]     timeout_duration,
    input  wire perc_bus_state_t      bus_state_init,
    input  wire logic                 married_init,
    input  wire logic                 init_load,
    input  wire logic                 report_valid,
    input  wire perc_report_t         report,
    input  wire logic                 split_write_pending,
    input  wire logic                 module_error_line_in,
    input  wire logic                 local_req,
    input  wire logic                 local_err_detect,
    input  wire logic                 ecc_correctable,
    output logic                      permanent_flag,
    output perc_bus_state_t           bus_state,
    output logic                      local_enable,
    output logic                      memory_enabled,
    output logic                      married,
    output logic                      bus_select_output,
    output logic                      module_error_line_rx_enable,
    output logic                      module_error_line_out,
    output logic                      report_enable,
    output logic                      report_as_busmod,
    output logic                      buffer_check_enable,
    output logic                      req_enable,
    output logic                      split_span_lock,
    output logic                      reconfig_msg,
    output logic                      staged_mode,
    output logic                      ecc_log_pulse,
    output logic                      window_open
);

    perc_state_t        state_reg;
    logic [TMO_W-1:0]   tmo_cnt_reg;
    logic [TMO_UNIT_CW-1:0] unit_cnt_reg;
    logic               unit_tick;
    perc_report_t       first_reg;
    logic               mel_s2_reg;
    logic               match;
    logic               mod_isolated_reg;
    logic               bus_isolated_reg;
    logic               in_bus;
    logic               in_mod;
    logic               in_both;
    // Decoded decisions; the isolation and activation hits are taken from the logged first report.
    logic               mod_deact;
    logic               both_isolated;
    logic               iso_mod_hit;
    logic               iso_bus_hit;
    logic               act_spouse_hit;
    logic               act_backup_hit;
    logic               lock_hit;

    assign unit_tick = (unit_cnt_reg == TMO_UNIT_CW'(TMO_UNIT_CYC - 1));

    // The error line is an asynchronous pin and must be synchronised.
    perc_sync2 u_mel_sync (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .async_in (module_error_line_in),
        .sync_out (mel_s2_reg)
    );

    always_comb begin
        case (report.etype)
            PERC_ET_BUS:    match = (report.bus_id == first_reg.bus_id);
            PERC_ET_MODULE: match = (report.module_id == first_reg.module_id);
            PERC_ET_BUSMOD: match = (report.bus_id == first_reg.bus_id) &&
                                    (report.module_id == first_reg.module_id);
            // ECC reports never match; staging hides them inside the window.
            default:        match = 1'b0;
        endcase
        match = match && (report.etype == first_reg.etype);
    end

    // Membership of the faulty area, judged by this node alone.
    always_comb begin
        in_bus  = (first_reg.bus_id == own_bus_id);
        in_mod  = (first_reg.module_id == own_module_id);
        in_both = 1'b0;
        case (first_reg.etype)
            PERC_ET_BUS:    in_both = 1'b0;
            PERC_ET_MODULE: in_both = 1'b0;
            PERC_ET_BUSMOD: in_both = in_bus && in_mod;
            default:        in_both = 1'b0;
        endcase
    end

    // Isolation and activation hits, decoded once from the logged first report.
    // A bus/module report names one bus and one module; the node at their crossing
    // fences off both, which also ends its own reports as a memory node.
    always_comb begin
        iso_mod_hit = 1'b0;
        iso_bus_hit = 1'b0;
        case (first_reg.etype)
            PERC_ET_BUS:    iso_bus_hit = in_bus;
            PERC_ET_MODULE: iso_mod_hit = in_mod;
            PERC_ET_BUSMOD: begin
                iso_mod_hit = in_both;
                iso_bus_hit = in_both;
            end
            default: begin
                iso_mod_hit = 1'b0;
                iso_bus_hit = 1'b0;
            end
        endcase
        // Bus faults name no spouse module, so they never unmarry a pair.
        act_spouse_hit = married && (first_reg.module_id == partner_module_id) &&
                         (first_reg.etype != PERC_ET_BUS);
        // The redundant bit covers both four-way interleave and a redundant bus.
        act_backup_hit = !is_memory_node && (first_reg.etype == PERC_ET_BUS) &&
                         (first_reg.bus_id == backup_bus_id) &&
                         (bus_state.en_primary || bus_state.en_backup) &&
                         bus_state.redundant;
        // Damage is possible only when neither a spouse nor a spare bus masks it.
        lock_hit = split_write_pending && !married && !bus_state.redundant;
    end

    // A processor module is fenced off whole; a memory module keeps all checks but the buffer check.
    assign mod_deact     = mod_isolated_reg && !is_memory_node;
    assign both_isolated = mod_isolated_reg && bus_isolated_reg;

    // Timebase: one unit tick per timeout unit; duration counts ticks.
    // The counter rests at zero while idle, so every sequence starts on a whole unit.
    always_ff @(posedge clk_sys) begin
        if (srst || state_reg == PERC_ST_IDLE || unit_tick) begin
            unit_cnt_reg <= '0;
        end else begin
            unit_cnt_reg <= unit_cnt_reg + 1'b1;
        end
    end

    // Sequencer: first report starts the quiescent period, then the window.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg   <= PERC_ST_IDLE;
            tmo_cnt_reg <= '0;
            first_reg   <= '0;
        end else begin
            case (state_reg)
                PERC_ST_IDLE: begin
                    if (report_valid && report.etype != PERC_ET_ECC) begin
                        first_reg   <= report;
                        tmo_cnt_reg <= timeout_duration;
                        state_reg   <= PERC_ST_QUIET;
                    end
                end
                // Reports during the quiet period are retried traffic and are ignored.
                PERC_ST_QUIET: begin
                    if (unit_tick) begin
                        if (tmo_cnt_reg == '0) begin
                            tmo_cnt_reg <= timeout_duration;
                            state_reg   <= PERC_ST_WINDOW;
                        end else begin
                            tmo_cnt_reg <= tmo_cnt_reg - 1'b1;
                        end
                    end
                end
                PERC_ST_WINDOW: begin
                    if (report_valid && match) begin
                        state_reg <= PERC_ST_ISOLATE;
                    end else if (unit_tick) begin
                        if (tmo_cnt_reg == '0) begin
                            // No match in time: the first error was a transient.
                            state_reg <= PERC_ST_IDLE;
                        end else begin
                            tmo_cnt_reg <= tmo_cnt_reg - 1'b1;
                        end
                    end
                end
                PERC_ST_ISOLATE: state_reg <= PERC_ST_ACTIVATE;
                PERC_ST_ACTIVATE: state_reg <= PERC_ST_IDLE;
                default: state_reg <= PERC_ST_IDLE;
            endcase
        end
    end

    // Permanent flag is sticky until reset.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            permanent_flag <= 1'b0;
        end else if (state_reg == PERC_ST_WINDOW && report_valid && match) begin
            permanent_flag <= 1'b1;
        end
    end

    // Isolation, evaluated in the single isolate cycle.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_state         <= BUS_STATE_RST;
            local_enable      <= LOCAL_EN_RST;
            memory_enabled    <= MEM_EN_RST;
            married           <= MARRIED_RST;
            bus_select_output <= 1'b0;
            mod_isolated_reg  <= 1'b0;
            bus_isolated_reg  <= 1'b0;
        end else if (init_load) begin
            bus_state <= bus_state_init;
            married   <= married_init;
        end else if (state_reg == PERC_ST_ISOLATE) begin
            // A memory node only drops its address range and stays on its bus.
            if (iso_mod_hit) begin
                mod_isolated_reg <= 1'b1;
                if (is_memory_node) begin
                    memory_enabled <= 1'b0;
                end else begin
                    bus_state    <= BUS_STATE_RST;
                    local_enable <= 1'b0;
                end
            end
            // Interface traffic to registers may still use a fenced bus.
            if (iso_bus_hit) begin
                bus_isolated_reg <= 1'b1;
                if (!is_memory_node) begin
                    bus_state.en_primary <= 1'b0;
                    bus_state.en_backup  <= 1'b0;
                end else if (bus_state.backup_avail) begin
                    bus_select_output <= ~bus_select_output;
                end else begin
                    bus_state <= BUS_STATE_RST;
                end
            end
        end else if (state_reg == PERC_ST_ACTIVATE) begin
            if (act_spouse_hit) begin
                married <= 1'b0;
            end
            if (act_backup_hit) begin
                bus_state.en_primary <= 1'b1;
                bus_state.en_backup  <= 1'b1;
            end
        end
    end

    // Error line receive and propagation follow the isolation state.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            module_error_line_rx_enable        <= 1'b1;
            module_error_line_out <= 1'b0;
        end else begin
            module_error_line_rx_enable        <= !mod_deact;
            // A dead bus must not carry a neighbour's error line into the system.
            module_error_line_out <= mel_s2_reg && !bus_isolated_reg &&
                                     !mod_deact;
        end
    end

    // Reporting: a memory node keeps reporting until it is fenced on both sides.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            report_enable    <= 1'b1;
            report_as_busmod <= 1'b0;
        end else begin
            // Detection stays on; only the report type changes.
            report_as_busmod <= mod_isolated_reg && local_err_detect;
            if (is_memory_node) begin
                report_enable <= !both_isolated;
            end else begin
                report_enable <= !bus_isolated_reg;
            end
        end
    end

    // Checks and own requests of a deactivated module.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            buffer_check_enable <= 1'b1;
            req_enable          <= 1'b1;
        end else begin
            buffer_check_enable <= !(is_memory_node && mod_isolated_reg);
            // Answers to other processors are not gated here, only own requests.
            req_enable          <= local_req && !mod_deact;
        end
    end

    // The lock is sticky: only a fresh reset frees the damaged memory.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            split_span_lock <= 1'b0;
        end else if (state_reg == PERC_ST_ACTIVATE && lock_hit) begin
            split_span_lock <= 1'b1;
        end
    end

    // Local pulse only; nothing goes out on the shared memory bus.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reconfig_msg <= 1'b0;
        end else begin
            reconfig_msg <= (state_reg == PERC_ST_ACTIVATE) && !is_memory_node;
        end
    end

    // Window status: a memory node stages data and logs corrected ECC silently.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            staged_mode   <= 1'b0;
            ecc_log_pulse <= 1'b0;
            window_open   <= 1'b0;
        end else begin
            staged_mode   <= (state_reg == PERC_ST_WINDOW) && is_memory_node;
            ecc_log_pulse <= (state_reg == PERC_ST_WINDOW) && is_memory_node &&
                             ecc_correctable;
            window_open   <= (state_reg == PERC_ST_WINDOW);
        end
    end

endmodule : perc_node

// Two-flop synchroniser for one asynchronous pin.
module perc_sync2
    import perc_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;

    // Only the second flop is read outside, so metastability stays inside.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : perc_sync2

// File: rtl/perc_pkg.sv
// Purpose: Shared constants and types for the permanent error reconfiguration node.
// Assumes: One system clock at 125 MHz; synchronous active-high reset.
// Notes:   Functional notes follow.
// Functional notes
// - Permanent only if second report inside window.
// - Same error type and same confinement area.
// - Compare bus, module, or full node id.
// - Permanent sets log flag, starts reconfiguration.
// - Each node judges its own membership.
// - Faulty processor node clears all bus-state bits.
// - Faulty processor node clears local enable.
// - Faulty processor node ignores module error line.
// - Deactivated module requests nothing; still answers others.
// - Detection stays on; report bus/module type.
// - Faulty memory clears memory enable, stays on bus.
// - Deactivated memory keeps all checks but buffer.
// - Faulty bus: interface nodes clear both enables.
// - Memory node moves to backup or clears bits.
// - Faulty bus stops reports and error line.
// - Memory stops reports when bus and module isolated.
// - Each node acts alone within few cycles.
// - Partner match with married bit clears married.
// - Backup bus match sets both enables.
// - Memory node toggles bus select to backup.
// - Without redundancy lock split-span damaged memory.
// - Permanent decision raises local reconfiguration message; memory node raises none.
// - Message interrupts host or redirects general processor.
// - Window length equals quiescent period, same setting.
// - In window correct and log ECC silently.
package perc_pkg;

    localparam int ID_W      = 4;
    localparam int TMO_W     = 16;
    // Error type codes carried in a report.
    typedef enum logic [1:0] {
        PERC_ET_BUS    = 2'b00,
        PERC_ET_MODULE = 2'b01,
        PERC_ET_BUSMOD = 2'b10,
        PERC_ET_ECC    = 2'b11
    } perc_etype_t;

    typedef struct packed {
        perc_etype_t       etype;
        logic [ID_W-1:0]   bus_id;
        logic [ID_W-1:0]   module_id;
    } perc_report_t;

    // Bus-state bits: primary enable, backup enable, backup available, interleave/redundant.
    typedef struct packed {
        logic en_primary;
        logic en_backup;
        logic backup_avail;
        logic redundant;
    } perc_bus_state_t;

    localparam perc_bus_state_t BUS_STATE_RST = 4'h0;
    localparam logic            LOCAL_EN_RST  = 1'b1;
    localparam logic            MEM_EN_RST    = 1'b1;
    localparam logic            MARRIED_RST   = 1'b0;
    // One timeout unit is this many cycles; unit scaled by the duration setting.
    localparam int TMO_UNIT_NS   = 1000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int TMO_UNIT_CYC  = (TMO_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMO_UNIT_CW   = 8;

    typedef enum logic [2:0] {
        PERC_ST_IDLE    = 3'b000,
        PERC_ST_QUIET   = 3'b001,
        PERC_ST_WINDOW  = 3'b010,
        PERC_ST_ISOLATE = 3'b011,
        PERC_ST_ACTIVATE= 3'b100
    } perc_state_t;

endpackage : perc_pkg

// File: test/perc_chk.sv
// Purpose: Assertions on the outputs of the reconfiguration node.
// Assumes: One clock domain; srst holds every check off.
// Notes:   Bound to every perc_node instance.
`timescale 1ns/1ps
module perc_chk
    import perc_pkg::*;
(
    input wire logic            clk_sys,
    input wire logic            srst,
    input wire logic            is_memory_node,
    input wire logic            report_valid,
    input wire logic            window_open,
    input wire logic            permanent_flag,
    input wire logic            reconfig_msg,
    input wire logic            local_enable,
    input wire logic            memory_enabled,
    input wire logic            married,
    input wire logic            module_error_line_rx_enable,
    input wire logic            req_enable,
    input wire logic            buffer_check_enable,
    input wire logic            report_as_busmod,
    input wire logic            bus_select_output,
    input wire perc_bus_state_t bus_state
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_perm_in_window;
        $rose(permanent_flag) |-> $past(report_valid) && window_open;
    endproperty
    a_perm_in_window: assert property (p_perm_in_window) else $error("flag without match");
    property p_msg_after;
        $rose(permanent_flag) && !is_memory_node |-> ##[1:4] reconfig_msg;
    endproperty
    a_msg_after: assert property (p_msg_after) else $error("no reconfig message");
    property p_msg_once;
        reconfig_msg |-> permanent_flag ##1 !reconfig_msg;
    endproperty
    a_msg_once: assert property (p_msg_once) else $error("message not single");
    property p_proc_iso;
        $fell(local_enable) |-> permanent_flag ##[0:3]
            (bus_state == BUS_STATE_RST && !module_error_line_rx_enable && !req_enable);
    endproperty
    a_proc_iso: assert property (p_proc_iso) else $error("module not isolated");
    property p_mem_iso;
        $fell(memory_enabled) |-> permanent_flag ##[0:3]
            (!buffer_check_enable && report_as_busmod);
    endproperty
    a_mem_iso: assert property (p_mem_iso) else $error("memory not isolated");
    property p_married;
        $fell(married) |-> permanent_flag;
    endproperty
    a_married: assert property (p_married) else $error("married cleared early");
    property p_bus_select_output;
        $changed(bus_select_output) |-> is_memory_node && permanent_flag;
    endproperty
    a_bus_select_output: assert property (p_bus_select_output) else $error("bus select moved");
    property p_window_min;
        $rose(window_open) |-> window_open [*8];
    endproperty
    a_window_min: assert property (p_window_min) else $error("window too short");
endmodule : perc_chk

bind perc_node perc_chk u_chk (.clk_sys, .srst, .is_memory_node, .report_valid, .window_open,
    .permanent_flag, .reconfig_msg, .local_enable, .memory_enabled, .married, .module_error_line_rx_enable,
    .req_enable, .buffer_check_enable, .report_as_busmod, .bus_select_output, .bus_state);

// File: test/perc_peer.sv
// Purpose: Model of a peer node that broadcasts error reports.
// Assumes: Reports are one-cycle strobes on the system clock.
// Notes:   The bench calls send for each report it wants seen.
`timescale 1ns/1ps
module perc_peer
    import perc_pkg::*;
(
    input  wire logic   clk_sys,
    output logic        report_valid,
    output perc_report_t report
);
    initial begin
        report_valid = 1'b0;
        report       = '0;
    end
    // Between strobes the field carries the inverse, so stale data never passes as fresh.
    task automatic send(input perc_report_t r);
        @(posedge clk_sys);
        report_valid <= 1'b1;
        report       <= r;
        @(posedge clk_sys);
        report_valid <= 1'b0;
        report       <= ~r;
    endtask : send
endmodule : perc_peer

// File: test/testbench.sv
// Purpose: Self-checking bench for the reconfiguration node.
// Assumes: Timeout setting 0, so quiet and window last one unit each.
// Notes:   Each case resets, loads state and plays a report, a non-matching report, then the repeat.
`timescale 1ns/1ps
module testbench import perc_pkg::*;;
    logic clk_sys = 1'b0, srst = 1'b1, is_memory_node = 1'b0, init_load = 1'b0;
    logic married_init = 1'b0, split_write_pending = 1'b0, module_error_line_in = 1'b0;
    logic local_req = 1'b1, local_err_detect = 1'b0, ecc_correctable = 1'b0;
    perc_bus_state_t bus_state_init = '0, bus_state;
    logic report_valid;
    perc_report_t report;
    logic permanent_flag, local_enable, memory_enabled, married, bus_select_output;
    logic module_error_line_rx_enable, module_error_line_out, report_enable, report_as_busmod;
    logic buffer_check_enable, req_enable, split_span_lock, reconfig_msg;
    logic staged_mode, ecc_log_pulse, window_open;
    int bad_count = 0, checks_done = 0, cyc = 0, msgs;
    perc_node DUT (.clk_sys, .srst, .is_memory_node, .own_bus_id(4'h1), .own_module_id(4'h2),
        .partner_module_id(4'h3), .backup_bus_id(4'h5), .timeout_duration(16'h0000),
        .bus_state_init, .married_init, .init_load, .report_valid, .report,
        .split_write_pending, .module_error_line_in, .local_req, .local_err_detect,
        .ecc_correctable, .permanent_flag, .bus_state, .local_enable, .memory_enabled,
        .married, .bus_select_output, .module_error_line_rx_enable, .module_error_line_out, .report_enable,
        .report_as_busmod, .buffer_check_enable, .req_enable, .split_span_lock, .reconfig_msg,
        .staged_mode, .ecc_log_pulse, .window_open);
    perc_peer peer (.clk_sys, .report_valid, .report);
    initial forever #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    function automatic perc_report_t mk(perc_etype_t t, logic [3:0] b, logic [3:0] m);
        return '{t, b, m};
    endfunction : mk
    task automatic start(input logic mem, input logic [3:0] bsi, input logic mi, input logic sp);
        @(posedge clk_sys);
        srst <= 1'b1;
        is_memory_node <= mem;
        bus_state_init <= bsi;
        married_init <= mi;
        split_write_pending <= sp;
        local_req <= ~mem;
        local_err_detect <= 1'b1;
        module_error_line_in <= ~mem;
        ecc_correctable <= mem;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        init_load <= 1'b1;
        @(posedge clk_sys);
        init_load <= 1'b0;
    endtask : start
    task automatic run_case(input logic mem, input logic [3:0] bsi, input logic mi,
                            input logic sp, input perc_report_t r, input perc_report_t d);
        int i;
        start(mem, bsi, mi, sp);
        peer.send(r);
        i = 0;
        while (window_open !== 1'b1 && i < 400) begin
            @(negedge clk_sys);
            i++;
        end
        repeat (10) @(negedge clk_sys);
        check(window_open, 1'b1);
        check({staged_mode, ecc_log_pulse}, {mem, mem});
        check(module_error_line_out, !mem);
        peer.send(d);
        repeat (3) @(negedge clk_sys);
        check(permanent_flag, 1'b0);
        peer.send(r);
        msgs = 0;
        repeat (8) begin
            @(negedge clk_sys);
            if (reconfig_msg === 1'b1) msgs++;
        end
        check(permanent_flag, 1'b1);
        check(16'(msgs), !mem);
    endtask : run_case
    initial begin
        start(1'b0, 4'hC, 1'b0, 1'b0);
        @(negedge clk_sys);
        check({local_enable, memory_enabled, married, report_enable, bus_state}, 16'h00DC);
        peer.send(mk(PERC_ET_ECC, 4'h1, 4'h2));
        repeat (200) @(negedge clk_sys);
        check(window_open, 1'b0);
        peer.send(mk(PERC_ET_MODULE, 4'h1, 4'h2));
        repeat (400) @(negedge clk_sys);
        check({permanent_flag, window_open}, 2'h0);
        run_case(0, 4'hC, 0, 0, mk(PERC_ET_MODULE, 4'h1, 4'h2), mk(PERC_ET_BUS, 4'h1, 4'h2));
        check(local_enable, 1'b0);
        check(bus_state, 4'h0);
        check({module_error_line_rx_enable, req_enable, module_error_line_out}, 3'h0);
        check(report_as_busmod, 1'b1);
        run_case(0, 4'hC, 1, 0, mk(PERC_ET_MODULE, 4'h1, 4'h3), mk(PERC_ET_MODULE, 4'h1, 4'h4));
        check({married, local_enable}, 2'h1);
        run_case(0, 4'h9, 0, 0, mk(PERC_ET_BUS, 4'h5, 4'h9), mk(PERC_ET_BUS, 4'h6, 4'h9));
        check(bus_state, 4'hD);
        run_case(0, 4'hC, 0, 1, mk(PERC_ET_BUS, 4'h1, 4'h9), mk(PERC_ET_MODULE, 4'h1, 4'h9));
        check({bus_state.en_primary, bus_state.en_backup}, 2'h0);
        check({report_enable, module_error_line_out}, 2'h0);
        check(split_span_lock, 1'b1);
        run_case(1, 4'h8, 0, 0, mk(PERC_ET_MODULE, 4'h1, 4'h2), mk(PERC_ET_MODULE, 4'h1, 4'h7));
        check({memory_enabled, report_as_busmod, bus_select_output}, 3'h2);
        check(buffer_check_enable, 1'b0);
        check(report_enable, 1'b1);
        run_case(1, 4'hA, 0, 0, mk(PERC_ET_BUS, 4'h1, 4'h9), mk(PERC_ET_BUS, 4'h2, 4'h9));
        check(bus_select_output, 1'b1);
        run_case(1, 4'h8, 0, 0, mk(PERC_ET_BUS, 4'h1, 4'h9), mk(PERC_ET_ECC, 4'h1, 4'h9));
        check(bus_state, 4'h0);
        run_case(1, 4'h8, 0, 0, mk(PERC_ET_BUSMOD, 4'h1, 4'h2), mk(PERC_ET_BUSMOD, 4'h2, 4'h2));
        check({report_enable, memory_enabled}, 2'h0);
        tally_and_finish();
    end
endmodule : testbench
